// [dv/pde_pin_model.sv]
// Board model for both ports: pad resolution with a board pullup on port D only.
// Assumes the bench sets switches on port D and drivers on port E.
`timescale 1ns/100ps
`include "pde_params.svh"

module pde_pin_model (
    // Pad drive from the block
    input wire logic [`PDE_D_W-1:0] portDOut,
    input wire logic [`PDE_D_W-1:0] portDOen,
    input wire logic [`PDE_E_W-1:0] portEOut,
    input wire logic [`PDE_E_W-1:0] portEOen,
    // Board devices
    input wire logic [`PDE_D_W-1:0] extDPullLow,
    input wire logic [`PDE_E_W-1:0] extELevel,
    // Pad levels back to the block
    output logic [`PDE_D_W-1:0] portDIn,
    output logic [`PDE_E_W-1:0] portEIn
);
    // Port D wired-AND: pullup high unless the block or a switch sinks it
    assign portDIn = ~((~portDOen & ~portDOut) | extDPullLow);
    // Port E: a driving block wins, else the board level
    assign portEIn = (~portEOen & portEOut) | (portEOen & extELevel);
endmodule

// [dv/tb_port_d_e_gpio.sv]
// Self-checking bench for the two-port GPIO block.
// Assumes the board model above and the register offsets of the params header.
`timescale 1ns/100ps
`include "pde_params.svh"

module tb_port_d_e_gpio;
    import pde_pkg::*;
    // ************************************
    // Signals, tasks and sequence
    // ************************************
    localparam logic [15:0] DDAT = `PDE_OFS_D_DATA;
    localparam logic [15:0] DDIR = `PDE_OFS_D_DIR;
    localparam logic [15:0] EDAT = `PDE_OFS_E_DATA;
    localparam logic [15:0] EDIR = `PDE_OFS_E_DIR;
    logic clk, resetn, wrStrobe, rdStrobe;
    logic [15:0] addr;
    logic [7:0] wrData, rdData;
    logic ledDirectDriveSelect, infraredDriveSelect, bit4PullupEnable, bit3PullupEnable;
    logic lowBitsPullupEnable, bit4InterruptEnable, usbFunctionEnable, dminusPullupEnable;
    logic [1:0] timer2EdgeLevel, timer1EdgeLevel;
    logic [2:0] prescalerSelect;
    logic timer2ChannelOut, timer2ChannelOe, timer1ChannelOut, timer1ChannelOe;
    logic usbDminusOut, usbDplusOut, usbDriveEnable;
    logic [5:0] portDIn, portDOut, portDOen, portDHighSink, portDInfraredSink, extDPullLow;
    logic [4:0] portEIn, portEOut, portEOen, portEPullup, extELevel;
    logic dminusPullup, extIrqPin, timerExtClock, timer2ChannelIn, timer1ChannelIn;
    int failCount = 0;
    int nChecks = 0;

    pde_gpio uut (.clk, .resetn, .addr, .wrData, .wrStrobe, .rdStrobe, .rdData,
        .ledDirectDriveSelect, .infraredDriveSelect, .bit4PullupEnable, .bit3PullupEnable,
        .lowBitsPullupEnable, .bit4InterruptEnable, .usbFunctionEnable, .dminusPullupEnable,
        .timer2EdgeLevel, .timer1EdgeLevel, .prescalerSelect, .timer2ChannelOut,
        .timer2ChannelOe, .timer1ChannelOut, .timer1ChannelOe, .usbDminusOut, .usbDplusOut,
        .usbDriveEnable, .portDIn, .portDOut, .portDOen, .portDHighSink, .portDInfraredSink,
        .portEIn, .portEOut, .portEOen, .portEPullup, .dminusPullup, .extIrqPin,
        .timerExtClock, .timer2ChannelIn, .timer1ChannelIn);
    pde_pin_model board (.portDOut, .portDOen, .portEOut, .portEOen, .extDPullLow,
        .extELevel, .portDIn, .portEIn);

    // Clock of 100 ns
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Verdict and end of run
    task automatic completeRun();
        $display("Checks %0d, mismatches %0d", nChecks, failCount);
        if (failCount == 0 && nChecks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        nChecks++;
        if (got !== exp) begin
            failCount++;
            $display("MISMATCH at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // Waits n edges, then settles 1 ns past the last one
    task automatic pins(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Write: strobe raised just after an edge, lowered at the edge that takes it
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wrData <= d;
        wrStrobe <= 1'b1;
        @(posedge clk);
        wrStrobe <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rdStrobe <= 1'b1;
        @(posedge clk);
        rdStrobe <= 1'b0;
        #1;
        chk(rdData, exp);
    endtask

    // Watchdog well beyond the expected run
    initial begin
        repeat (5000) @(posedge clk);
        failCount++;
        completeRun();
    end

    // Main sequence
    initial begin
        {resetn, wrStrobe, rdStrobe, addr, wrData} = '0;
        {ledDirectDriveSelect, infraredDriveSelect, bit4PullupEnable, bit3PullupEnable} = '0;
        {lowBitsPullupEnable, bit4InterruptEnable, usbFunctionEnable, dminusPullupEnable} = '0;
        {timer2EdgeLevel, timer1EdgeLevel, prescalerSelect} = '0;
        {timer2ChannelOut, timer2ChannelOe, timer1ChannelOut, timer1ChannelOe} = '0;
        {usbDminusOut, usbDplusOut, usbDriveEnable, extDPullLow, extELevel} = '0;
        repeat (4) @(posedge clk);
        resetn <= 1'b1;
        pins(1);
        rd(DDIR, 8'h00);
        rd(EDIR, 8'h00);
        chk(8'(portDOen), 8'h3F);
        rd(16'h0004, 8'h00);
        // Port D input path, latch writes while input
        @(posedge clk);
        extDPullLow <= 6'h2A;
        pins(3);
        rd(DDAT, 8'h15);
        wr(DDAT, 8'h0F);
        rd(DDAT, 8'h15);
        @(posedge clk);
        extDPullLow <= 6'h00;
        wr(DDIR, 8'hFF);
        rd(DDIR, 8'h3F);
        rd(DDAT, 8'h0F);
        pins(2);
        chk(8'(portDOen), 8'h0F);
        chk(8'(portDOut), 8'h00);
        // Reset in mid-run keeps the latch
        @(posedge clk);
        resetn <= 1'b0;
        pins(2);
        chk(8'(portDOen), 8'h3F);
        @(posedge clk);
        resetn <= 1'b1;
        pins(1);
        rd(DDIR, 8'h00);
        wr(DDIR, 8'h3C);
        rd(DDAT, 8'h0F);
        // Sink mode selects
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            {ledDirectDriveSelect, infraredDriveSelect} <= 2'(i);
            pins(3);
            chk(8'(portDHighSink), i[1] ? 8'h3C : 8'h00);
            chk(8'(portDInfraredSink), i[0] ? 8'h03 : 8'h00);
        end
        // Port E registers
        @(posedge clk);
        extELevel <= 5'h0A;
        pins(3);
        rd(EDAT, 8'h0A);
        wr(EDAT, 8'hE5);
        rd(EDAT, 8'h0A);
        wr(EDIR, 8'hFF);
        rd(EDIR, 8'h1F);
        rd(EDAT, 8'h05);
        pins(2);
        chk(8'(portEOen), 8'h00);
        chk(8'(portEOut), 8'h05);
        wr(EDAT, 8'h18);
        {bit4PullupEnable, bit3PullupEnable, lowBitsPullupEnable} <= 3'b111;
        pins(3);
        chk(8'(portEOen), 8'h18);
        chk(8'(portEPullup), 8'h07);
        wr(EDIR, 8'h00);
        pins(3);
        chk(8'(portEPullup), 8'h1F);
        // USB owns bits 4 and 3
        @(posedge clk);
        {usbFunctionEnable, dminusPullupEnable, usbDriveEnable, usbDminusOut} <= 4'hF;
        pins(3);
        chk(8'(portEPullup), 8'h07);
        chk(8'(dminusPullup), 8'h01);
        chk(8'(portEOen), 8'h07);
        chk(8'(portEOut[4:3]), 8'h02);
        // Bit 4 as interrupt input
        @(posedge clk);
        {usbDriveEnable, bit4InterruptEnable} <= 2'b01;
        pins(3);
        chk(8'(extIrqPin), 8'h01);
        @(posedge clk);
        usbFunctionEnable <= 1'b0;
        pins(3);
        chk(8'(extIrqPin), 8'h00);
        @(posedge clk);
        extELevel <= 5'h1A;
        pins(3);
        chk(8'(extIrqPin), 8'h01);
        // Timer channels own bits 2 and 1
        @(posedge clk);
        {timer2EdgeLevel, timer1EdgeLevel} <= 4'b0110;
        {timer2ChannelOe, timer2ChannelOut} <= 2'b11;
        wr(EDIR, 8'h02);
        pins(3);
        chk(8'(portEOen[2:1]), 8'h01);
        chk(8'(portEOut[2]), 8'h01);
        chk(8'(timer1ChannelIn), 8'h01);
        chk(8'(timer2ChannelIn), 8'h01);
        rd(EDAT, 8'h1C);
        // Bit 0 as timer clock
        @(posedge clk);
        extELevel <= 5'h1B;
        prescalerSelect <= 3'd7;
        pins(3);
        chk(8'(timerExtClock), 8'h01);
        @(posedge clk);
        prescalerSelect <= 3'd3;
        pins(3);
        chk(8'(timerExtClock), 8'h00);
        completeRun();
    end
endmodule

// [rtl/pde_gpio.sv]
// Port D (6-bit open-drain) and port E (5-bit shared) GPIO with registers.
// Assumes pin inputs synchronous to clk, option and ownership bits driven
// by the option register, USB, timer and interrupt blocks elsewhere.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps
`include "pde_params.svh"

module pde_gpio
    import pde_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Register port
    input wire logic [`PDE_ADDR_W-1:0] addr,
    input wire logic [`PDE_DATA_W-1:0] wrData,
    input wire logic wrStrobe,
    input wire logic rdStrobe,
    output logic [`PDE_DATA_W-1:0] rdData,
    // Port options from elsewhere
    input wire logic ledDirectDriveSelect,
    input wire logic infraredDriveSelect,
    input wire logic bit4PullupEnable,
    input wire logic bit3PullupEnable,
    input wire logic lowBitsPullupEnable,
    input wire logic bit4InterruptEnable,
    input wire logic usbFunctionEnable,
    input wire logic dminusPullupEnable,
    // Timer ownership and signals
    input wire logic [1:0] timer2EdgeLevel,
    input wire logic [1:0] timer1EdgeLevel,
    input wire logic [2:0] prescalerSelect,
    input wire logic timer2ChannelOut,
    input wire logic timer2ChannelOe,
    input wire logic timer1ChannelOut,
    input wire logic timer1ChannelOe,
    // USB transceiver signals
    input wire logic usbDminusOut,
    input wire logic usbDplusOut,
    input wire logic usbDriveEnable,
    // Port D pins
    input wire logic [`PDE_D_W-1:0] portDIn,
    output logic [`PDE_D_W-1:0] portDOut,
    output logic [`PDE_D_W-1:0] portDOen,
    output logic [`PDE_D_W-1:0] portDHighSink,
    output logic [`PDE_D_W-1:0] portDInfraredSink,
    // Port E pins
    input wire logic [`PDE_E_W-1:0] portEIn,
    output logic [`PDE_E_W-1:0] portEOut,
    output logic [`PDE_E_W-1:0] portEOen,
    output logic [`PDE_E_W-1:0] portEPullup,
    output logic dminusPullup,
    // Alternate inputs to other blocks
    output logic extIrqPin,
    output logic timerExtClock,
    output logic timer2ChannelIn,
    output logic timer1ChannelIn
);

    // ******************************************************
    // Decode helpers
    // ******************************************************

    // Returns the register hit by an address, valid flag in bit 2
    function automatic logic [2:0] decodeAddr(input logic [`PDE_ADDR_W-1:0] a);
        case (a)
            `PDE_OFS_D_DATA: decodeAddr = {1'b1, PDE_REG_D_DATA};
            `PDE_OFS_D_DIR: decodeAddr = {1'b1, PDE_REG_D_DIR};
            `PDE_OFS_E_DATA: decodeAddr = {1'b1, PDE_REG_E_DATA};
            `PDE_OFS_E_DIR: decodeAddr = {1'b1, PDE_REG_E_DIR};
            default: decodeAddr = 3'b000;
        endcase
    endfunction

    // Timer channel owns its pin when edge/level bits are nonzero
    function automatic logic timerOwns(input logic [1:0] els);
        timerOwns = |els;
    endfunction

    // ******************************************************
    // Register state
    // ******************************************************

    logic [`PDE_D_W-1:0] dLatch;
    logic [`PDE_D_W-1:0] dDir;
    logic [`PDE_E_W-1:0] eLatch;
    logic [`PDE_E_W-1:0] eDir;
    logic [`PDE_D_W-1:0] next_dLatch;
    logic [`PDE_D_W-1:0] next_dDir;
    logic [`PDE_E_W-1:0] next_eLatch;
    logic [`PDE_E_W-1:0] next_eDir;
    logic [`PDE_DATA_W-1:0] next_rdData;
    logic [2:0] hit;

    assign hit = decodeAddr(addr);

    // Next values of latches, directions and read data
    always_comb begin
        next_dLatch = dLatch;
        next_dDir = dDir;
        next_eLatch = eLatch;
        next_eDir = eDir;
        next_rdData = 8'h00;
        if (wrStrobe && hit[2]) begin
            case (pde_reg_type'(hit[1:0]))
                PDE_REG_D_DATA: next_dLatch = wrData[`PDE_D_W-1:0];
                PDE_REG_D_DIR: next_dDir = wrData[`PDE_D_W-1:0];
                PDE_REG_E_DATA: next_eLatch = wrData[`PDE_E_W-1:0];
                PDE_REG_E_DIR: next_eDir = wrData[`PDE_E_W-1:0];
                default: next_dLatch = dLatch;
            endcase
        end
        if (rdStrobe && hit[2]) begin
            case (pde_reg_type'(hit[1:0]))
                // Output bits read latch, input bits read the pin
                PDE_REG_D_DATA:
                    next_rdData = {2'b00, (dDir & dLatch) | (~dDir & portDIn)};
                PDE_REG_D_DIR: next_rdData = {2'b00, dDir};
                PDE_REG_E_DATA:
                    next_rdData = {3'b000, (eDir & eLatch) | (~eDir & portEIn)};
                PDE_REG_E_DIR: next_rdData = {3'b000, eDir};
                default: next_rdData = 8'h00;
            endcase
        end
    end

    // Latches have no reset; directions and read data clear
    always_ff @(posedge clk) begin
        dLatch <= next_dLatch;
        eLatch <= next_eLatch;
    end

    // Directions and read data
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            dDir <= `PDE_DIR_D_RESET;
            eDir <= `PDE_DIR_E_RESET;
            rdData <= 8'h00;
        end else begin
            dDir <= next_dDir;
            eDir <= next_eDir;
            rdData <= next_rdData;
        end
    end

    // ******************************************************
    // Pin control
    // ******************************************************

    logic [`PDE_D_W-1:0] next_portDOut;
    logic [`PDE_D_W-1:0] next_portDOen;
    logic [`PDE_D_W-1:0] next_portDHighSink;
    logic [`PDE_D_W-1:0] next_portDInfraredSink;
    logic [`PDE_E_W-1:0] next_portEOut;
    logic [`PDE_E_W-1:0] next_portEOen;
    logic [`PDE_E_W-1:0] next_portEPullup;
    logic next_dminusPullup;
    logic next_extIrqPin;
    logic next_timerExtClock;
    logic next_timer2ChannelIn;
    logic next_timer1ChannelIn;
    logic [`PDE_E_W-1:0] eDrive;
    logic [`PDE_E_W-1:0] eLevel;

    // Port D open-drain: enable low only when an output latch holds 0
    genvar gi;
    generate
        for (gi = 0; gi < `PDE_D_W; gi++) begin : gDPin
            assign next_portDOut[gi] = 1'b0;
            assign next_portDOen[gi] = ~(dDir[gi] & ~dLatch[gi]);
            if (gi >= 2) begin : gLed
                assign next_portDHighSink[gi] = ledDirectDriveSelect;
                assign next_portDInfraredSink[gi] = 1'b0;
            end else begin : gIr
                assign next_portDHighSink[gi] = 1'b0;
                assign next_portDInfraredSink[gi] = infraredDriveSelect;
            end
        end
    endgenerate

    // Port E ownership, drive and pullups
    always_comb begin
        eDrive = eDir;
        eLevel = eLatch;
        next_portEPullup = '0;
        // Timer channels take direction and level from the timer
        if (timerOwns(timer2EdgeLevel)) begin
            eDrive[`PDE_BIT_T2CH] = timer2ChannelOe;
            eLevel[`PDE_BIT_T2CH] = timer2ChannelOut;
        end
        if (timerOwns(timer1EdgeLevel)) begin
            eDrive[`PDE_BIT_T1CH] = timer1ChannelOe;
            eLevel[`PDE_BIT_T1CH] = timer1ChannelOut;
        end
        // Selected external clock makes bit 0 a pure input
        if (prescalerSelect == `PDE_PS_EXT_CLK) begin
            eDrive[`PDE_BIT_TIMER_EXT_CLOCK_PIN] = 1'b0;
        end
        // Low three bits are push-pull general outputs
        next_portEOut[2:0] = eLevel[2:0];
        next_portEOen[2:0] = ~eDrive[2:0];
        next_portEPullup[2:0] = {3{lowBitsPullupEnable}};
        if (usbFunctionEnable) begin
            // USB transceiver owns D- and D+
            next_portEOut[4:3] = {usbDminusOut, usbDplusOut};
            next_portEOen[4:3] = {2{~usbDriveEnable}};
        end else begin
            // Open-drain: drive low only for an output latch of 0
            next_portEOut[4:3] = 2'b00;
            next_portEOen[4:3] = ~(eDir[4:3] & ~eLatch[4:3]);
            next_portEPullup[4] = bit4PullupEnable & ~eDir[4];
            next_portEPullup[3] = bit3PullupEnable & ~eDir[3];
        end
        next_dminusPullup = usbFunctionEnable & dminusPullupEnable;
        next_extIrqPin = bit4InterruptEnable & ~usbFunctionEnable
            ? portEIn[`PDE_BIT_USBDM] : 1'b1;
        next_timerExtClock = prescalerSelect == `PDE_PS_EXT_CLK
            ? portEIn[`PDE_BIT_TIMER_EXT_CLOCK_PIN] : 1'b0;
        next_timer2ChannelIn = portEIn[`PDE_BIT_T2CH];
        next_timer1ChannelIn = portEIn[`PDE_BIT_T1CH];
    end

    // Register every pin and alternate output
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            portDOut <= '0;
            portDOen <= '1;
            portDHighSink <= '0;
            portDInfraredSink <= '0;
            portEOut <= '0;
            portEOen <= '1;
            portEPullup <= '0;
            dminusPullup <= 1'b0;
            extIrqPin <= 1'b1;
            timerExtClock <= 1'b0;
            timer2ChannelIn <= 1'b0;
            timer1ChannelIn <= 1'b0;
        end else begin
            portDOut <= next_portDOut;
            portDOen <= next_portDOen;
            portDHighSink <= next_portDHighSink;
            portDInfraredSink <= next_portDInfraredSink;
            portEOut <= next_portEOut;
            portEOen <= next_portEOen;
            portEPullup <= next_portEPullup;
            dminusPullup <= next_dminusPullup;
            extIrqPin <= next_extIrqPin;
            timerExtClock <= next_timerExtClock;
            timer2ChannelIn <= next_timer2ChannelIn;
            timer1ChannelIn <= next_timer1ChannelIn;
        end
    end

    // ******************************************************
    // Checks
    // ******************************************************

    sequence dDirWrite;
        wrStrobe && addr == `PDE_OFS_D_DIR;
    endsequence

    property dirTakesWrite;
        @(posedge clk) disable iff (!resetn)
            dDirWrite |=> dDir == $past(wrData[5:0]);
    endproperty

    d_dir_write_a: assert property (dirTakesWrite)
        else $error("port D direction did not take write");

    d_open_drain_a: assert property (@(posedge clk) disable iff (!resetn)
        portDOut == 6'h00)
        else $error("port D drove high");

    d_read_mux_a: assert property (@(posedge clk) disable iff (!resetn)
        rdStrobe && addr == `PDE_OFS_D_DATA |=>
            rdData == {2'b00, ($past(dDir) & $past(dLatch))
                | (~$past(dDir) & $past(portDIn))})
        else $error("port D read mux wrong");

    e_read_mux_a: assert property (@(posedge clk) disable iff (!resetn)
        rdStrobe && addr == `PDE_OFS_E_DATA |=>
            rdData == {3'b000, ($past(eDir) & $past(eLatch))
                | (~$past(eDir) & $past(portEIn))})
        else $error("port E read mux wrong");

    latch_write_a: assert property (@(posedge clk) disable iff (!resetn)
        wrStrobe && addr == `PDE_OFS_E_DATA |=> eLatch == $past(wrData[4:0]))
        else $error("port E latch write lost");

    upper_zero_a: assert property (@(posedge clk) disable iff (!resetn)
        rdData[7:6] == 2'b00)
        else $error("upper read bits not zero");

    e_pullup_a: assert property (@(posedge clk) disable iff (!resetn)
        usbFunctionEnable |=> portEPullup[4:3] == 2'b00)
        else $error("port E pullup on while USB enabled");

    irq_gate_a: assert property (@(posedge clk) disable iff (!resetn)
        usbFunctionEnable |=> extIrqPin)
        else $error("interrupt pin passed with USB on");

    low_pullup_a: assert property (@(posedge clk) disable iff (!resetn)
        portEPullup[2:0] == {3{$past(lowBitsPullupEnable)}})
        else $error("low pullups wrong");

    // Reset held over an edge leaves every direction bit clear
    sequence heldReset;
        !resetn ##1 !resetn;
    endsequence

    dir_reset_a: assert property (@(posedge clk)
        heldReset |-> dDir == `PDE_DIR_D_RESET && eDir == `PDE_DIR_E_RESET)
        else $error("direction bits not cleared by reset");

    // A port D latch write lands whatever the direction
    sequence dDataWrite;
        wrStrobe && addr == `PDE_OFS_D_DATA;
    endsequence

    d_latch_write_a: assert property (@(posedge clk) disable iff (!resetn)
        dDataWrite |=> dLatch == $past(wrData[5:0]))
        else $error("port D latch write lost");

    // Port E direction register takes its write
    sequence eDirWrite;
        wrStrobe && addr == `PDE_OFS_E_DIR;
    endsequence

    e_dir_write_a: assert property (@(posedge clk) disable iff (!resetn)
        eDirWrite |=> eDir == $past(wrData[4:0]))
        else $error("port E direction did not take write");

    // USB off: bits 4 and 3 are open-drain general pins
    sequence usbOff;
        !usbFunctionEnable;
    endsequence

    e_open_drain_a: assert property (@(posedge clk) disable iff (!resetn)
        usbOff |=> portEOut[4:3] == 2'b00)
        else $error("port E bit 4 or 3 drove high");

    // Bit 4 as an output loses its general pullup
    e_pull_input_a: assert property (@(posedge clk) disable iff (!resetn)
        usbOff ##0 eDir[`PDE_BIT_USBDM] |=> !portEPullup[`PDE_BIT_USBDM])
        else $error("bit 4 pullup on while output");

    // Interrupt input follows bit 4 only with USB off
    irq_pass_a: assert property (@(posedge clk) disable iff (!resetn)
        usbOff ##0 bit4InterruptEnable |=> extIrqPin == $past(portEIn[`PDE_BIT_USBDM]))
        else $error("interrupt pin does not follow bit 4");

    // Timer owns bit 2: level and drive come from the channel
    sequence t2Owned;
        timerOwns(timer2EdgeLevel);
    endsequence

    timer_drive_a: assert property (@(posedge clk) disable iff (!resetn)
        t2Owned |=> portEOen[`PDE_BIT_T2CH] == !$past(timer2ChannelOe)
            && portEOut[`PDE_BIT_T2CH] == $past(timer2ChannelOut))
        else $error("timer channel does not drive bit 2");

    // Selected external clock keeps bit 0 undriven
    timer_ext_clock_pin_input_a: assert property (@(posedge clk) disable iff (!resetn)
        prescalerSelect == `PDE_PS_EXT_CLK |=> portEOen[`PDE_BIT_TIMER_EXT_CLOCK_PIN])
        else $error("bit 0 driven while timer clock");

endmodule

// [rtl/pde_params.svh]
// Constants of the two-port GPIO block: offsets, widths and reset values.
// Assumes an 8-bit register port with byte addresses.
`ifndef PDE_PARAMS_SVH
`define PDE_PARAMS_SVH
`define PDE_ADDR_W 16
`define PDE_DATA_W 8
`define PDE_D_W 6
`define PDE_E_W 5
`define PDE_OFS_D_DATA 16'h0003
`define PDE_OFS_D_DIR 16'h0007
`define PDE_OFS_E_DATA 16'h0008
`define PDE_OFS_E_DIR 16'h0009
`define PDE_DIR_D_RESET 6'h00
`define PDE_DIR_E_RESET 5'h00
`define PDE_BIT_USBDM 4
`define PDE_BIT_USBDP 3
`define PDE_BIT_T2CH 2
`define PDE_BIT_T1CH 1
`define PDE_BIT_TIMER_EXT_CLOCK_PIN 0
`define PDE_PS_EXT_CLK 3'h7
`endif

// [rtl/pde_pkg.sv]
// Types shared by the two-port GPIO block.
// Assumes the constants header is included alongside.
package pde_pkg;
    typedef enum logic [1:0] {
        PDE_REG_D_DATA = 2'b00,
        PDE_REG_D_DIR = 2'b01,
        PDE_REG_E_DATA = 2'b11,
        PDE_REG_E_DIR = 2'b10
    } pde_reg_type;
endpackage
